/* File: inc/flash_lock_pkg.sv */
// Package with command codes, status bit positions, register map and carriers for the lock host.
package flash_lock_pkg;
  // Flash command codes.
  localparam logic [7:0] CMD_LOCK_SETUP    = 8'h60;
  localparam logic [7:0] CMD_LOCK_BLOCK    = 8'h01;
  localparam logic [7:0] CMD_LOCK_MASTER   = 8'hF1;
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  // Status bit positions of operation_status.
  localparam int SR_READY   = 7;
  localparam int SR_ESUSP   = 6;
  localparam int SR_ERASE   = 5;
  localparam int SR_PROG    = 4;
  localparam int SR_VPP     = 3;
  localparam int SR_PSUSP   = 2;
  localparam int SR_PROT    = 1;
  localparam logic [7:0] SR_USED_MASK = 8'hFE;
  // APB register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0C;
  // Control register fields.
  localparam int CTRL_GO     = 0;
  localparam int CTRL_MASTER = 1;
  localparam int CTRL_CHECK  = 2;
  localparam int CTRL_CLEAR  = 3;
  localparam int CTRL_FINISH = 4;
  localparam int CTRL_AUTO_CHECK = 5;
  // Result codes of the full status check.
  localparam logic [2:0] RES_OK      = 3'h0;
  localparam logic [2:0] RES_VPP     = 3'h1;
  localparam logic [2:0] RES_PROTECT = 3'h2;
  localparam logic [2:0] RES_SEQ     = 3'h3;
  localparam logic [2:0] RES_LOCK    = 3'h4;
  // Bus timing: a strobe phase lasts this many clock cycles plus one.
  localparam int STROBE_CYCLES = 2;
  // One bus cycle request to the flash pin engine.
  typedef struct packed {
    logic        write;
    logic [21:0] addr;
    logic [7:0]  data;
  } bus_req_type;
endpackage

/* File: verilog/flash_bus_cycle.sv */
// Single byte-wide asynchronous flash bus cycle engine.
`timescale 1ns/10ps
`default_nettype none
module flash_bus_cycle #(
  parameter int AW = 22
) (
  input  wire logic                          i_mclk,
  input  wire logic                          i_rstn,
  input  wire logic                          i_start,
  input  wire flash_lock_pkg::bus_req_type   i_req,
  output logic                               o_done,
  output logic [7:0]                         o_rdata,
  output logic [AW-1:0]                      o_addr,
  output logic [7:0]                         o_dq_out,
  output logic                               o_dq_oe_n,
  output logic                               o_ce_n,
  output logic                               o_oe_n,
  output logic                               o_we_n,
  input  wire logic [7:0]                    i_dq_in
);
  // The request carrier holds a fixed address width, so other widths are refused at build time.
  if (AW != 22)
  begin : g_bad_aw
    $error("flash_bus_cycle supports AW of 22 only");
  end
  typedef enum logic [1:0] {IDLE, STROBE, RELEASE} cyc_state_type;
  cyc_state_type state_r;
  logic [2:0]    cnt_r;
  logic [7:0]    dq_s1_r;
  logic [7:0]    dq_s2_r;
  logic          wr_r;
  wire  logic    cnt_end = (cnt_r == 3'(flash_lock_pkg::STROBE_CYCLES));

  // Data pins pass two flops before being captured, which costs two strobe cycles.
  always_ff @(posedge i_mclk)
  begin
    dq_s1_r <= i_dq_in;
    dq_s2_r <= dq_s1_r;
  end

  // Strobe sequencer: chip enable plus write or output enable for a fixed span.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      state_r   <= IDLE;
      cnt_r     <= 3'h0;
      o_done    <= 1'b0;
      o_rdata   <= 8'h00;
      o_addr    <= '0;
      o_dq_out  <= 8'h00;
      o_dq_oe_n <= 1'b1;
      o_ce_n    <= 1'b1;
      o_oe_n    <= 1'b1;
      o_we_n    <= 1'b1;
      wr_r      <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      unique case (state_r)
        IDLE:
        begin
          if (i_start)
          begin
            o_addr    <= i_req.addr;
            o_dq_out  <= i_req.data;
            o_dq_oe_n <= !i_req.write;
            wr_r      <= i_req.write;
            o_ce_n    <= 1'b0;
            o_we_n    <= !i_req.write;
            o_oe_n    <= i_req.write;
            cnt_r     <= 3'h0;
            state_r   <= STROBE;
          end
        end
        STROBE:
        begin
          cnt_r <= cnt_r + 3'h1;
          if (cnt_end)
          begin
            // Sampled before the strobe rises so the data is still valid.
            if (!wr_r) o_rdata <= dq_s2_r;
            o_ce_n  <= 1'b1;
            o_we_n  <= 1'b1;
            o_oe_n  <= 1'b1;
            state_r <= RELEASE;
          end
        end
        RELEASE:
        begin
          // Data held one cycle past write strobe for hold time.
          o_dq_oe_n <= 1'b1;
          o_done    <= 1'b1;
          state_r   <= IDLE;
        end
      endcase
    end
  end
endmodule // flash_bus_cycle
`default_nettype wire

/* File: verilog/flash_lock_host.sv */
// Host controller that sets block and master lock-bits on an asynchronous flash over APB orders.
`timescale 1ns/10ps
`default_nettype none
module flash_lock_host #(
  parameter int AW = 22
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rstn,
  input  wire logic          i_psel,
  input  wire logic          i_penable,
  input  wire logic          i_pwrite,
  input  wire logic [7:0]    i_paddr,
  input  wire logic [31:0]   i_pwdata,
  output logic [31:0]        o_prdata,
  output logic               o_pready,
  output logic               o_pslverr,
  output logic [AW-1:0]      o_flash_addr,
  output logic [7:0]         o_flash_dq_out,
  output logic               o_flash_dq_oe_n,
  input  wire logic [7:0]    i_flash_dq_in,
  output logic               o_flash_ce_n,
  output logic               o_flash_oe_n,
  output logic               o_flash_we_n,
  input  wire logic          i_ready_busy_out
);
  // The request carrier holds a fixed address width, so other widths are refused at build time.
  if (AW != 22)
  begin : g_bad_aw
    $error("flash_lock_host supports AW of 22 only");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_CONFIRM, S_POLL, S_CHECK, S_CLEAR, S_FINISH, S_WAIT
  } host_state_type;

  host_state_type state_r;
  host_state_type ret_r;
  logic [AW-1:0]  addr_r;
  logic           master_r;
  logic           auto_check_r;
  logic [7:0]     sr_r;
  logic [2:0]     result_r;
  logic           busy_r;
  logic           rb_s1_r;
  logic           rb_s2_r;
  logic           start_r;
  flash_lock_pkg::bus_req_type req_r;
  wire  logic     cyc_done;
  wire  logic [7:0] cyc_rdata;

  // Ready/busy pin crosses in via two flops; the poll uses both pin and status bit.
  always_ff @(posedge i_mclk)
  begin
    rb_s1_r <= i_ready_busy_out;
    rb_s2_r <= rb_s1_r;
  end

  // APB decode; every access completes in its first access cycle.
  wire logic apb_acc   = i_psel && i_penable;
  wire logic apb_wr    = apb_acc && i_pwrite;
  wire logic hit_ctrl  = (i_paddr == flash_lock_pkg::REG_CTRL);
  wire logic hit_addr  = (i_paddr == flash_lock_pkg::REG_ADDR);
  wire logic hit_stat  = (i_paddr == flash_lock_pkg::REG_STATUS);
  wire logic hit_res   = (i_paddr == flash_lock_pkg::REG_RESULT);
  wire logic hit_any   = hit_ctrl || hit_addr || hit_stat || hit_res;
  wire logic ctrl_wr   = apb_wr && hit_ctrl && !busy_r;
  wire logic go_cmd    = ctrl_wr && i_pwdata[flash_lock_pkg::CTRL_GO];
  wire logic chk_cmd   = ctrl_wr && i_pwdata[flash_lock_pkg::CTRL_CHECK];
  wire logic clr_cmd   = ctrl_wr && i_pwdata[flash_lock_pkg::CTRL_CLEAR];
  wire logic fin_cmd   = ctrl_wr && i_pwdata[flash_lock_pkg::CTRL_FINISH];
  // Status masks the reserved bit so software never sees a stray value in it.
  wire logic [7:0] sr_masked = sr_r & flash_lock_pkg::SR_USED_MASK;
  // Ready needs both the status bit and the pin, since the pin stays high in suspend.
  wire logic flash_ready = cyc_rdata[flash_lock_pkg::SR_READY] && rb_s2_r;
  // Read data is only fresh after a read cycle; after a write it still holds an old status.
  wire logic rd_fresh    = !req_r.write;

  assign o_pready  = 1'b1;
  assign o_pslverr = apb_acc && (!hit_any || (apb_wr && (hit_stat || hit_res)));
  assign o_prdata  = hit_ctrl ? {31'h0, busy_r} :
                     hit_addr ? {{(32-AW){1'b0}}, addr_r} :
                     hit_stat ? {24'h0, sr_masked} :
                     hit_res  ? {29'h0, result_r} : 32'h0;

  // Full status check ordering: supply, protection, sequence, then lock error.
  function automatic logic [2:0] classify(input logic [7:0] sr);
    if (sr[flash_lock_pkg::SR_VPP])
      classify = flash_lock_pkg::RES_VPP;
    else if (sr[flash_lock_pkg::SR_PROT])
      classify = flash_lock_pkg::RES_PROTECT;
    else if (sr[flash_lock_pkg::SR_PROG] && sr[flash_lock_pkg::SR_ERASE])
      classify = flash_lock_pkg::RES_SEQ;
    else if (sr[flash_lock_pkg::SR_PROG])
      classify = flash_lock_pkg::RES_LOCK;
    else
      classify = flash_lock_pkg::RES_OK;
  endfunction

  // Order sequencer: each step except S_CLEAR, S_FINISH and a ready S_POLL issues one flash bus cycle and then waits for it.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
    begin
      state_r      <= S_IDLE;
      ret_r        <= S_IDLE;
      addr_r       <= '0;
      master_r     <= 1'b0;
      auto_check_r <= 1'b0;
      sr_r         <= 8'h00;
      result_r     <= flash_lock_pkg::RES_OK;
      busy_r       <= 1'b0;
      start_r      <= 1'b0;
      req_r        <= '0;
    end
    else
    begin
      start_r <= 1'b0;
      if (apb_wr && hit_addr && !busy_r)
        addr_r <= i_pwdata[AW-1:0];
      unique case (state_r)
        S_IDLE:
        begin
          if (go_cmd)
          begin
            master_r     <= i_pwdata[flash_lock_pkg::CTRL_MASTER];
            auto_check_r <= i_pwdata[flash_lock_pkg::CTRL_AUTO_CHECK];
            busy_r       <= 1'b1;
            req_r        <= '{1'b1, addr_r, flash_lock_pkg::CMD_LOCK_SETUP};
            start_r      <= 1'b1;
            ret_r        <= S_CONFIRM;
            state_r      <= S_WAIT;
          end
          else if (chk_cmd)
          begin
            // Series check relies on the flash keeping error bits sticky.
            busy_r  <= 1'b1;
            req_r   <= '{1'b1, addr_r, flash_lock_pkg::CMD_READ_STATUS};
            start_r <= 1'b1;
            ret_r   <= S_CHECK;
            state_r <= S_WAIT;
          end
          else if (clr_cmd)
          begin
            // Software clears after an error, before any retry.
            busy_r  <= 1'b1;
            req_r   <= '{1'b1, addr_r, flash_lock_pkg::CMD_CLEAR_STATUS};
            start_r <= 1'b1;
            ret_r   <= S_CLEAR;
            state_r <= S_WAIT;
          end
          else if (fin_cmd)
          begin
            busy_r  <= 1'b1;
            req_r   <= '{1'b1, addr_r, flash_lock_pkg::CMD_READ_ARRAY};
            start_r <= 1'b1;
            ret_r   <= S_FINISH;
            state_r <= S_WAIT;
          end
        end
        S_CONFIRM:
        begin
          req_r   <= '{1'b1, addr_r, master_r ? flash_lock_pkg::CMD_LOCK_MASTER
                                              : flash_lock_pkg::CMD_LOCK_BLOCK};
          start_r <= 1'b1;
          ret_r   <= S_POLL;
          state_r <= S_WAIT;
        end
        S_POLL:
        begin
          // After confirm the flash reads back status, so plain reads poll it.
          // Right after the confirm write no status has been read yet, so a read goes first.
          if (rd_fresh)
            sr_r <= cyc_rdata;
          if (rd_fresh && flash_ready)
          begin
            if (auto_check_r)
              result_r <= classify(cyc_rdata);
            busy_r  <= 1'b0;
            state_r <= S_IDLE;
          end
          else
          begin
            req_r   <= '{1'b0, addr_r, 8'h00};
            start_r <= 1'b1;
            ret_r   <= S_POLL;
            state_r <= S_WAIT;
          end
        end
        S_CHECK:
        begin
          // Status read after the read-status command; bits 6 and 2 report suspends.
          req_r   <= '{1'b0, addr_r, 8'h00};
          start_r <= 1'b1;
          ret_r   <= S_POLL;
          auto_check_r <= 1'b1;
          state_r <= S_WAIT;
        end
        S_CLEAR:
        begin
          result_r <= flash_lock_pkg::RES_OK;
          sr_r     <= 8'h00;
          busy_r   <= 1'b0;
          state_r  <= S_IDLE;
        end
        S_FINISH:
        begin
          busy_r  <= 1'b0;
          state_r <= S_IDLE;
        end
        S_WAIT:
        begin
          if (cyc_done)
            state_r <= ret_r;
        end
      endcase
    end
  end

  flash_bus_cycle #(.AW(AW)) u_cycle (
    .i_mclk    (i_mclk),
    .i_rstn    (i_rstn),
    .i_start   (start_r),
    .i_req     (req_r),
    .o_done    (cyc_done),
    .o_rdata   (cyc_rdata),
    .o_addr    (o_flash_addr),
    .o_dq_out  (o_flash_dq_out),
    .o_dq_oe_n (o_flash_dq_oe_n),
    .o_ce_n    (o_flash_ce_n),
    .o_oe_n    (o_flash_oe_n),
    .o_we_n    (o_flash_we_n),
    .i_dq_in   (i_flash_dq_in)
  );
endmodule // flash_lock_host
`default_nettype wire

/* File: tb/flash_lock_host_properties.sv */
// Concurrent checks on the lock host's APB port and flash pins.
`timescale 1ns/10ps
`default_nettype none
module flash_lock_host_properties #(
  parameter int AW = 22
) (
  input wire logic          i_mclk,
  input wire logic          i_rstn,
  input wire logic          i_psel,
  input wire logic          i_penable,
  input wire logic          i_pwrite,
  input wire logic [7:0]    i_paddr,
  input wire logic          o_pready,
  input wire logic          o_pslverr,
  input wire logic [AW-1:0] o_flash_addr,
  input wire logic [7:0]    o_flash_dq_out,
  input wire logic          o_flash_dq_oe_n,
  input wire logic          o_flash_ce_n,
  input wire logic          o_flash_oe_n,
  input wire logic          o_flash_we_n,
  input wire logic          i_ready_busy_out
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  logic [7:0] last_cmd_r;
  wire        access_w = i_psel && i_penable;
  // The last command byte is kept so that a confirm can be tied to its setup.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rstn)
      last_cmd_r <= 8'h00;
    else if ($fell(o_flash_we_n))
      last_cmd_r <= o_flash_dq_out;
  end
  // A strobe pulse is three cycles low with the other strobes settled around it.
  sequence s_write;
    (!o_flash_we_n && !o_flash_ce_n && !o_flash_dq_oe_n && o_flash_oe_n) [*3]
      ##1 (o_flash_we_n && o_flash_ce_n);
  endsequence
  sequence s_read;
    (!o_flash_oe_n && !o_flash_ce_n && o_flash_dq_oe_n && o_flash_we_n) [*3]
      ##1 (o_flash_oe_n && o_flash_ce_n);
  endsequence
  AST_WR_PULSE: assert property ($fell(o_flash_we_n) |-> s_write)
    else $error("flash write strobe shape wrong");
  AST_RD_PULSE: assert property ($fell(o_flash_oe_n) |-> s_read)
    else $error("flash read strobe shape wrong");
  AST_DQ_FREE: assert property ($rose(o_flash_we_n) |-> !o_flash_dq_oe_n ##1 o_flash_dq_oe_n)
    else $error("data bus not released one cycle after write");
  AST_CONFIRM: assert property ($fell(o_flash_we_n) && last_cmd_r == 8'h60
    |-> o_flash_dq_out inside {8'h01, 8'hF1})
    else $error("setup not followed by a confirm code");
  AST_SETUP_FIRST: assert property ($fell(o_flash_we_n) && o_flash_dq_out inside {8'h01, 8'hF1}
    |-> last_cmd_r == 8'h60)
    else $error("confirm code without setup");
  AST_ADDR_HELD: assert property (!o_flash_we_n && !$past(o_flash_we_n) |-> $stable(o_flash_addr))
    else $error("flash address moved during write");
  AST_NO_WR_BUSY: assert property (!i_ready_busy_out [*3] |-> !$fell(o_flash_we_n))
    else $error("command written while device busy");
  AST_PREADY: assert property (access_w |-> o_pready)
    else $error("apb wait state inserted");
  AST_UNMAPPED: assert property (access_w && !(i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})
    |-> o_pslverr)
    else $error("unmapped access without error");
  AST_RO_WRITE: assert property (access_w && i_pwrite && i_paddr inside {8'h08, 8'h0C}
    |-> o_pslverr)
    else $error("write to read-only register without error");
endmodule // flash_lock_host_properties
bind flash_lock_host flash_lock_host_properties #(.AW(AW)) u_flash_lock_host_properties (
  .i_mclk(i_mclk), .i_rstn(i_rstn), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_flash_addr(o_flash_addr), .o_flash_dq_out(o_flash_dq_out),
  .o_flash_dq_oe_n(o_flash_dq_oe_n), .o_flash_ce_n(o_flash_ce_n),
  .o_flash_oe_n(o_flash_oe_n), .o_flash_we_n(o_flash_we_n),
  .i_ready_busy_out(i_ready_busy_out)
);
`default_nettype wire

/* File: tb/flash_device_model.sv */
// Behavioural model of the byte-wide flash device and its status register.
`timescale 1ns/10ps
`default_nettype none
module flash_device_model #(
  parameter logic [7:0] ARRAY_BYTE = 8'hA5
) (
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [21:0] i_addr,
  input  wire logic [7:0]  i_dq_out,
  input  wire logic        i_dq_oe_n,
  input  wire logic        i_override,
  input  wire logic        i_vpp_low,
  input  wire logic        i_slow,
  input  wire logic [1:0]  i_fault,
  output logic [7:0]       o_dq,
  output logic             o_ready_busy_out
);
  logic [7:0]  sr = 8'h80;
  logic        setup_r = 1'b0;
  logic        in_array = 1'b1;
  logic        master_set = 1'b0;
  logic [21:0] lock_addr = 22'h000000;
  logic [7:0]  last = 8'h00;
  wire  [7:0]  rdv = in_array ? ARRAY_BYTE : {sr[7:1], 1'b0};
  // A released bus shows the inverse of its last value, so stale data never reads right.
  assign o_dq = (!i_ce_n && !i_oe_n) ? rdv : (!i_dq_oe_n ? i_dq_out : ~last);
  initial o_ready_busy_out = 1'b1;
  // Remember the last value put on the bus.
  always @(posedge i_oe_n) last = rdv;
  // Commands are taken shortly after the strobe falls, once data has settled.
  always @(negedge i_we_n)
  begin
    #10;
    if (!i_ce_n)
      take(i_dq_out, i_addr);
  end
  task automatic take(input logic [7:0] c, input logic [21:0] a);
    if (setup_r && (i_fault == 2'd1 || (c != 8'h01 && c != 8'hF1)))
    begin
      setup_r = 1'b0;
      sr[5:4] = 2'b11;
    end
    else if (setup_r)
    begin
      setup_r = 1'b0;
      sr[7] = 1'b0;
      o_ready_busy_out = 1'b0;
      #(i_slow ? 4000 : 300);
      if (i_vpp_low)
        sr[4:3] = 2'b11;
      else if (!i_override && (c == 8'hF1 || master_set))
        sr = sr | 8'h12;
      else if (i_fault == 2'd2)
        sr[4] = 1'b1;
      else if (c == 8'hF1)
        master_set = 1'b1;
      else
        lock_addr = a;
      sr[7] = 1'b1;
      o_ready_busy_out = 1'b1;
    end
    else
    begin
      setup_r = (c == 8'h60);
      in_array = (c == 8'hFF);
      if (c == 8'h50)
        sr = sr & 8'hC5;
    end
  endtask
endmodule // flash_device_model
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the flash lock host against a behavioural flash device.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, cap_rd;
  logic        pready, pslverr, er, cap_rdy, cap_err;
  logic [21:0] flash_addr;
  logic [7:0]  dq_out, dq_in;
  logic        dq_oe_n, ce_n, oe_n, we_n, rb;
  logic        override = 1'b0;
  logic        vpp_low = 1'b0;
  logic        slow = 1'b0;
  logic [1:0]  fault = 2'b00;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  always #50 mclk = ~mclk;
  flash_lock_host u_flash_lock_host (
    .i_mclk(mclk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_flash_addr(flash_addr), .o_flash_dq_out(dq_out),
    .o_flash_dq_oe_n(dq_oe_n), .i_flash_dq_in(dq_in), .o_flash_ce_n(ce_n),
    .o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .i_ready_busy_out(rb));
  flash_device_model u_flash_device_model (
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_addr(flash_addr), .i_dq_out(dq_out),
    .i_dq_oe_n(dq_oe_n), .i_override(override), .i_vpp_low(vpp_low), .i_slow(slow),
    .i_fault(fault), .o_dq(dq_in), .o_ready_busy_out(rb));
  // Answers are held mid-cycle, so the copy equals what the next rising edge sees.
  always @(negedge mclk)
  begin
    cap_rdy = pready;
    cap_rd = prdata;
    cap_err = pslverr;
  end
  // A hang is cut short well above the several hundred cycles the tests need.
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_bit(input string what, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, e, g);
    end
  endtask
  // One APB transfer; the request stands until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (cap_rdy !== 1'b1);
    rd = cap_rd;
    er = cap_err;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(w, a, d);
    chk_bit("pslverr", e, er);
    if (!w)
      chk_word("read data", d, rd);
  endtask
  task automatic wait_idle();
    do apb(1'b0, 8'h00, 32'h0); while (rd[0] !== 1'b0);
  endtask
  // Sets the device conditions, gives one order, then checks status and, when res is not negative, result.
  task automatic step(input logic [7:0] c, input logic [1:0] f, input logic o,
                      input logic v, input logic [7:0] st, input int res);
    fault <= f;
    override <= o;
    vpp_low <= v;
    acc(1'b1, 8'h04, 32'h002ABCDE, 1'b0);
    acc(1'b1, 8'h00, {24'h000000, c}, 1'b0);
    wait_idle();
    acc(1'b0, 8'h08, {24'h000000, st}, 1'b0);
    if (res >= 0)
      acc(1'b0, 8'h0C, res, 1'b0);
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    acc(1'b0, 8'h00, 32'h0, 1'b0);
    acc(1'b0, 8'h08, 32'h0, 1'b0);
    acc(1'b0, 8'h0C, 32'h0, 1'b0);
    acc(1'b1, 8'h10, 32'h0, 1'b1);
    acc(1'b1, 8'h08, 32'h0, 1'b1);
    step(8'h01, 2'd0, 1'b0, 1'b0, 8'h80, -1);
    chk_word("lock address", 32'h002ABCDE, {10'h000, u_flash_device_model.lock_addr});
    step(8'h23, 2'd0, 1'b0, 1'b0, 8'h92, 2);
    step(8'h01, 2'd0, 1'b0, 1'b0, 8'h92, -1);
    step(8'h01, 2'd1, 1'b0, 1'b0, 8'hB2, -1);
    step(8'h04, 2'd0, 1'b0, 1'b0, 8'hB2, 2);
    step(8'h08, 2'd0, 1'b0, 1'b0, 8'h00, 0);
    step(8'h04, 2'd0, 1'b0, 1'b0, 8'h80, 0);
    step(8'h21, 2'd1, 1'b0, 1'b0, 8'hB0, 3);
    step(8'h08, 2'd0, 1'b0, 1'b0, 8'h00, 0);
    step(8'h23, 2'd0, 1'b0, 1'b1, 8'h98, 1);
    step(8'h08, 2'd0, 1'b0, 1'b0, 8'h00, 0);
    step(8'h21, 2'd2, 1'b0, 1'b0, 8'h90, 4);
    step(8'h08, 2'd0, 1'b0, 1'b0, 8'h00, 0);
    slow <= 1'b1;
    step(8'h23, 2'd0, 1'b1, 1'b0, 8'h80, 0);
    slow <= 1'b0;
    step(8'h21, 2'd0, 1'b0, 1'b0, 8'h92, 2);
    acc(1'b1, 8'h00, 32'h00000010, 1'b0);
    wait_idle();
    chk_bit("array mode", 1'b1, u_flash_device_model.in_array);
    conclude();
  end
endmodule // tb_top
`default_nettype wire
